// [tpsc_power_ctrl.v]
// Operation
// - three host-selectable states: full, standby, off
// - full state keeps every subsystem but the link core clocked and enabled
// - standby disables the audio and video pipelines
// - standby keeps config port, cec, gpio, ddc master alive
// - serial link core enable follows software in full and standby; forced low while off
// - cec messaging still works in standby
// - identification data reads over display data channel work in standby
// - entering off stops all internal clocks
// - no register reads or writes answered while off
// - off state only raises hot-plug interrupt, if enabled beforehand
// - interrupt raised while off stays asserted
// - enabled pending interrupts drive int pin; status also pollable
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tpsc_defines.vh"

module tpsc_power_ctrl (
  input  wire                        clk,
  input  wire                        reset_n,
  input  wire                        psel,
  input  wire                        penable,
  input  wire                        pwrite,
  input  wire [`TPSC_ADDR_WIDTH-1:0] paddr,
  input  wire [31:0]                 pwdata,
  output wire                        pready,
  output reg  [31:0]                 prdata,
  output wire                        pslverr,
  input  wire                        hot_plug_in,
  input  wire                        rsense_in,
  output wire                        int_out,
  output wire                        audio_pipe_en,
  output wire                        video_pipe_en,
  output wire                        cfg_port_en,
  output wire                        cec_en,
  output wire                        gpio_en,
  output wire                        ddc_master_en,
  output wire                        link_core_en,
  output wire                        core_clk_en,
  output wire [1:0]                  power_state
);

  reg  [1:0]                 state_r;
  reg  [1:0]                 state_nxt;
  reg                        link_en_r;
  reg  [`TPSC_INT_WIDTH-1:0] int_en_r;
  reg  [`TPSC_INT_WIDTH-1:0] int_st_r;
  reg  [`TPSC_INT_WIDTH-1:0] int_st_nxt;
  wire [`TPSC_INT_WIDTH-1:0] rise;
  wire                       is_off;
  wire                       access;
  wire                       wr;
  wire                       rd;

  function sel_addr;
    input [`TPSC_ADDR_WIDTH-1:0] a;
    input [`TPSC_ADDR_WIDTH-1:0] ref_a;
    begin
      sel_addr = (a == ref_a);
    end
  endfunction

  function valid_state;
    input [1:0] s;
    begin
      valid_state = (s == `TPSC_ST_FULL) || (s == `TPSC_ST_STANDBY) ||
                    (s == `TPSC_ST_OFF);
    end
  endfunction

  tpsc_edge_detect u_edge (
    .clk      (clk),
    .reset_n  (reset_n),
    .level_in ({rsense_in, hot_plug_in}),
    .rise_out (rise)
  );

  assign is_off  = (state_r == `TPSC_ST_OFF);
  assign access  = psel & penable & ~is_off;
  // off: pready held low so the bus never completes, as no access exists
  assign pready  = ~is_off;
  assign pslverr = 1'b0;
  assign wr      = access & pwrite;
  // read data staged in the setup cycle, so it stands at the access edge
  assign rd      = psel & ~penable & ~pwrite & ~is_off;

  always @* begin
    state_nxt = state_r;
    if (wr && sel_addr(paddr, `TPSC_ADDR_PWR_CTRL) &&
        valid_state(pwdata[`TPSC_CTRL_STATE_MSB:`TPSC_CTRL_STATE_LSB])) begin
      state_nxt = pwdata[`TPSC_CTRL_STATE_MSB:`TPSC_CTRL_STATE_LSB];
    end
    // no write path leaves off; only reset does
    if (is_off) begin
      state_nxt = `TPSC_ST_OFF;
    end
  end

  always @* begin
    int_st_nxt = int_st_r;
    if (wr && sel_addr(paddr, `TPSC_ADDR_INT_STATUS)) begin
      int_st_nxt = int_st_r & ~pwdata[`TPSC_INT_WIDTH-1:0];
    end
    if (is_off) begin
      // only hot-plug events remain live while off
      int_st_nxt = int_st_r |
                   (rise & int_en_r &
                    (`TPSC_ZERO_INT | (2'h1 << `TPSC_INT_HOTPLUG)));
    end else begin
      int_st_nxt = int_st_nxt | (rise & int_en_r); // set beats clear
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state_r   <= `TPSC_ST_FULL;
      link_en_r <= 1'b0;
      int_en_r  <= `TPSC_ZERO_INT;
      int_st_r  <= `TPSC_ZERO_INT;
    end else begin
      state_r  <= state_nxt;
      int_st_r <= int_st_nxt;
      if (wr && sel_addr(paddr, `TPSC_ADDR_PWR_CTRL)) begin
        link_en_r <= pwdata[`TPSC_CTRL_LINK_BIT];
      end
      if (wr && sel_addr(paddr, `TPSC_ADDR_INT_ENABLE)) begin
        int_en_r <= pwdata[`TPSC_INT_WIDTH-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      prdata <= `TPSC_ZERO32;
    end else if (rd) begin
      if (sel_addr(paddr, `TPSC_ADDR_PWR_CTRL)) begin
        prdata <= {27'h000_0000, link_en_r, 2'h0, state_r};
      end else if (sel_addr(paddr, `TPSC_ADDR_PWR_STATUS)) begin
        prdata <= {25'h000_0000, core_clk_en, ddc_master_en, cec_en,
                   video_pipe_en, audio_pipe_en, state_r};
      end else if (sel_addr(paddr, `TPSC_ADDR_INT_ENABLE)) begin
        prdata <= {30'h0000_0000, int_en_r};
      end else if (sel_addr(paddr, `TPSC_ADDR_INT_STATUS)) begin
        prdata <= {30'h0000_0000, int_st_r};
      end else begin
        prdata <= `TPSC_ZERO32;
      end
    end
  end

  assign audio_pipe_en = (state_r == `TPSC_ST_FULL);
  assign video_pipe_en = (state_r == `TPSC_ST_FULL);
  assign cfg_port_en   = ~is_off;
  assign cec_en        = ~is_off;
  assign gpio_en       = ~is_off;
  assign ddc_master_en = ~is_off;
  assign core_clk_en   = ~is_off;
  // link core left to software, except it cannot run with clocks stopped
  assign link_core_en  = link_en_r & ~is_off;
  assign power_state   = state_r;
  assign int_out       = |int_st_r;

endmodule // tpsc_power_ctrl

// [tpsc_defines.vh]
`ifndef TPSC_DEFINES_VH
`define TPSC_DEFINES_VH

// register byte addresses
`define TPSC_ADDR_PWR_CTRL    12'h000
`define TPSC_ADDR_PWR_STATUS  12'h004
`define TPSC_ADDR_INT_ENABLE  12'h008
`define TPSC_ADDR_INT_STATUS  12'h00c
`define TPSC_ADDR_WIDTH       12

// power states
`define TPSC_ST_FULL          2'h0
`define TPSC_ST_STANDBY       2'h2
`define TPSC_ST_OFF           2'h3

// power control fields
`define TPSC_CTRL_STATE_LSB   0
`define TPSC_CTRL_STATE_MSB   1
`define TPSC_CTRL_LINK_BIT    4

// interrupt bits
`define TPSC_INT_HOTPLUG      0
`define TPSC_INT_RSENSE       1
`define TPSC_INT_WIDTH        2

`define TPSC_ZERO32           32'h0000_0000
`define TPSC_ZERO_INT         2'h0
`define TPSC_CTRL_RESET       2'h0

`endif

// [tpsc_edge_detect.v]
`timescale 1ns/1ps
`include "tpsc_defines.vh"

// rising-edge detector for event inputs; inputs already synchronous
module tpsc_edge_detect (
  input  wire                     clk,
  input  wire                     reset_n,
  input  wire [`TPSC_INT_WIDTH-1:0] level_in,
  output wire [`TPSC_INT_WIDTH-1:0] rise_out
);

  reg [`TPSC_INT_WIDTH-1:0] level_d_r;

  always @(posedge clk) begin
    if (!reset_n) begin
      level_d_r <= `TPSC_ZERO_INT;
    end else begin
      level_d_r <= level_in;
    end
  end

  assign rise_out = level_in & ~level_d_r;

endmodule // tpsc_edge_detect

// [tpsc_power_ctrl_properties.sv]
`timescale 1ns/1ps
module tpsc_props (
  input wire       clk,
  input wire       reset_n,
  input wire       pready,
  input wire       int_out,
  input wire       link_core_en,
  input wire       core_clk_en,
  input wire       audio_pipe_en,
  input wire       video_pipe_en,
  input wire       cec_en,
  input wire [1:0] power_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_full; !power_state |-> audio_pipe_en && video_pipe_en; endproperty
  a_full: assert property (p_full) else $error("full");
  property p_stby; power_state == 2'h2 |->
    !audio_pipe_en && !video_pipe_en && cec_en; endproperty
  a_stby: assert property (p_stby) else $error("stby");
  property p_off; &power_state |-> !core_clk_en && !pready; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_rdy; !(&power_state) |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("rdy");
  property p_hold; &power_state |=> &power_state; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_irq; &power_state && int_out |=> int_out; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_legal; power_state != 2'h1; endproperty
  a_legal: assert property (p_legal) else $error("state");
  property p_rst; $rose(reset_n) |-> !power_state && !int_out; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  c_link: cover property (power_state == 2'h2 && link_core_en);
  c_irq: cover property (&power_state && int_out);
  c_back: cover property (!power_state ##1 power_state == 2'h2);
endmodule // tpsc_props
bind tpsc_power_ctrl tpsc_props tpsc_props_inst (.*);

// [tpsc_host.sv]
`timescale 1ns/1ps
module tpsc_host (
  input wire        clk, pready,
  input wire [31:0] prdata,
  output reg        reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0,
  output reg [11:0] paddr = 12'h000,
  output reg [31:0] pwdata = 32'h0
);
  task automatic chip_reset;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  // no wait limit: a hang while off is cut by the bench
  task automatic xf(input [11:0] a, input w, input [31:0] d, output [31:0] q);
    @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1'b1;
    // pready and read data are taken at the same rising edge
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'h0;
  endtask
endmodule // tpsc_host

// [tpsc_power_ctrl_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t diff", $time); end end
module tpsc_power_ctrl_tb;
  logic        clk = 0, hot_plug_in = 0, rsense_in = 0, l;
  logic [1:0]  s;
  logic [31:0] q;
  wire         reset_n, psel, penable, pwrite, pready, pslverr, int_out;
  wire         audio_pipe_en, video_pipe_en, cec_en, gpio_en, cfg_port_en;
  wire         link_core_en, core_clk_en, ddc_master_en;
  wire [1:0]   power_state;
  wire [11:0]  paddr;
  wire [31:0]  pwdata, prdata;
  int          error_cnt = 0, n_compared = 0;
  initial forever #12.5 clk = ~clk;
  initial #100us stop_test(1);
  tpsc_power_ctrl tpsc_power_ctrl_inst (.*);
  tpsc_host tpsc_host_inst (.*);
  function automatic [31:0] exp_st(input [1:0] st);
    exp_st = {25'h0, 3'h7, {2{st == 2'h0}}, st};
  endfunction
  task automatic io(input [11:0] a, input w, input [31:0] d);
    tpsc_host_inst.xf(a, w, d, q);
    if (!w) `CHK(q, d)
  endtask
  // event held three cycles so the status bit has landed
  task automatic ev(input [1:0] v);
    @(posedge clk) {hot_plug_in, rsense_in} <= v;
    repeat (3) @(posedge clk);
    {hot_plug_in, rsense_in} <= 2'h0;
  endtask
  task automatic stop_test(input int to = 0);
    error_cnt += to;
    $display("errors %0d of %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(14151));
    tpsc_host_inst.chip_reset();
    io(12'h004, 0, exp_st(2'h0));
    repeat (6) begin
      {l, s} = $urandom & 3'h6;
      io(12'h000, 1, {27'h0, l, 2'h0, s});
      @(negedge clk);
      `CHK(link_core_en, l)
      `CHK({pslverr, power_state}, {1'b0, s})
      `CHK({cfg_port_en, gpio_en, ddc_master_en, core_clk_en}, 4'hf)
      `CHK({audio_pipe_en, video_pipe_en}, {2{s == 2'h0}})
      io(12'h004, 0, exp_st(s));
    end
    io(12'h000, 1, 32'h1);
    io(12'h000, 0, {30'h0, s});
    io(12'h0f0, 0, 32'h0);
    io(12'h008, 1, 32'h1);
    ev(2'h3);
    io(12'h00c, 0, 32'h1);
    io(12'h00c, 1, 32'h1);
    @(negedge clk);
    `CHK(int_out, 1'b0)
    io(12'h000, 1, 32'h3);
    ev(2'h2);
    @(negedge clk);
    `CHK(int_out, 1'b1)
    `CHK({core_clk_en, pready, power_state}, 4'h3)
    tpsc_host_inst.chip_reset();
    io(12'h00c, 0, 32'h0);
    stop_test();
  end
endmodule // tpsc_power_ctrl_tb
